// file: verilog/otpc_defs.svh
// constants for the one-time-programmable memory host controller
`ifndef OTPC_DEFS_SVH
`define OTPC_DEFS_SVH

`define OTPC_AW             17
`define OTPC_DW             8
`define OTPC_ID_SEL_BIT     0
`define OTPC_PW_BITS        5
`define OTPC_MAX_PULSES     5'h19
`define OTPC_TMR_BITS       12

`define OTPC_CLK_NS         40
`define OTPC_T_ACC_NS       250
`define OTPC_T_SETUP_NS     2000
`define OTPC_T_PW_NS        100000
`define OTPC_T_HOLD_NS      2000
`define OTPC_T_OEV_NS       150
`define OTPC_T_FLOAT_NS     130

`define OTPC_ACC_CYC   ((`OTPC_T_ACC_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
`define OTPC_SETUP_CYC ((`OTPC_T_SETUP_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
`define OTPC_PW_CYC    (`OTPC_T_PW_NS / `OTPC_CLK_NS)
`define OTPC_HOLD_CYC  ((`OTPC_T_HOLD_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
`define OTPC_OEV_CYC   ((`OTPC_T_OEV_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)
`define OTPC_FLOAT_CYC ((`OTPC_T_FLOAT_NS + `OTPC_CLK_NS - 1) / `OTPC_CLK_NS)

`endif

// file: verilog/otpc_pkg.sv
// types shared by the memory host controller
`include "otpc_defs.svh"
package otpc_pkg;

  typedef enum logic [1:0] {
    OP_READ   = 2'h0,
    OP_PROG   = 2'h1,
    OP_IDENT  = 2'h2,
    OP_VERIFY = 2'h3
  } otpc_op_t;

  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_SETUP    = 8'h02,
    ST_PULSE    = 8'h04,
    ST_HOLD     = 8'h08,
    ST_VFY_WAIT = 8'h10,
    ST_REFLOAT  = 8'h20,
    ST_ACCESS   = 8'h40,
    ST_FLOAT    = 8'h80
  } otpc_state_t;

  typedef struct packed {
    otpc_op_t               op;
    logic [`OTPC_AW-1:0]    addr;
    logic [`OTPC_DW-1:0]    data;
  } otpc_cmd_t;

  typedef struct packed {
    logic [`OTPC_DW-1:0]      data;
    logic                     match;
    logic                     parity_ok;
    logic [`OTPC_PW_BITS-1:0] pulses;
  } otpc_rsp_t;

  typedef struct packed {
    logic [`OTPC_AW-1:0] address_lines;
    logic                ce_n;
    logic                oe_n;
    logic                program_strobe_n;
    logic                vpp_prog;
    logic                identify_high_voltage;
  } otpc_pins_t;

endpackage

// file: verilog/otpc_timer.sv
// loadable down counter that times each pin phase
`timescale 1ns/1ps
`include "otpc_defs.svh"
module otpc_timer (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire logic                      load,
  input  wire logic [`OTPC_TMR_BITS-1:0] load_val,
  output logic                           done
);

  logic [`OTPC_TMR_BITS-1:0] cnt_q;

  // a load of n makes done rise after n enabled cycles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (load) begin
        cnt_q <= load_val - `OTPC_TMR_BITS'(1);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - `OTPC_TMR_BITS'(1);
      end
    end
  end

  assign done = (cnt_q == '0);

endmodule // otpc_timer

// file: verilog/otpc_ctrl.sv
// host controller driving the pins of a one-time-programmable byte memory
`timescale 1ns/1ps
`include "otpc_defs.svh"
module otpc_ctrl (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  input  otpc_pkg::otpc_cmd_t       cmd,
  output logic                      rsp_valid,
  output otpc_pkg::otpc_rsp_t       rsp,
  output otpc_pkg::otpc_pins_t      pins,
  output logic [`OTPC_DW-1:0]       data_lines_o,
  output logic                      data_lines_oe,
  input  wire logic [`OTPC_DW-1:0]  data_lines_i
);

  localparam int PW_CYC = `OTPC_PW_CYC;

  otpc_pkg::otpc_state_t      state_q;
  otpc_pkg::otpc_state_t      state_d;
  otpc_pkg::otpc_cmd_t        cur_q;
  logic [`OTPC_PW_BITS-1:0]   pulses_q;
  logic                       tmr_load;
  logic [`OTPC_TMR_BITS-1:0]  tmr_val;
  logic                       tmr_done;
  logic                       match;
  logic                       prog_finish;
  logic                       accept;
  logic [`OTPC_TMR_BITS-1:0]  low_cnt_q;

  assign cmd_ready = (state_q == otpc_pkg::ST_IDLE);
  assign accept    = cmd_valid && cmd_ready;
  // compare: a cleared bit cannot return to one
  assign match     = (data_lines_i == cur_q.data);
  assign prog_finish = match || (pulses_q >= `OTPC_MAX_PULSES);

  otpc_timer u_timer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  always_comb begin
    state_d  = state_q;
    tmr_load = 1'b0;
    tmr_val  = `OTPC_TMR_BITS'(1);
    case (state_q)
      otpc_pkg::ST_IDLE: begin
        if (cmd_valid) begin
          tmr_load = 1'b1;
          if (cmd.op == otpc_pkg::OP_PROG) begin
            state_d = otpc_pkg::ST_SETUP;
            tmr_val = `OTPC_TMR_BITS'(`OTPC_SETUP_CYC);
          end else begin
            state_d = otpc_pkg::ST_ACCESS;
            tmr_val = `OTPC_TMR_BITS'(`OTPC_ACC_CYC);
          end
        end
      end
      otpc_pkg::ST_SETUP: begin
        if (tmr_done) begin
          state_d  = otpc_pkg::ST_PULSE;
          tmr_load = 1'b1;
          tmr_val  = `OTPC_TMR_BITS'(`OTPC_PW_CYC);
        end
      end
      otpc_pkg::ST_PULSE: begin
        if (tmr_done) begin
          state_d  = otpc_pkg::ST_HOLD;
          tmr_load = 1'b1;
          tmr_val  = `OTPC_TMR_BITS'(`OTPC_HOLD_CYC);
        end
      end
      otpc_pkg::ST_HOLD: begin
        if (tmr_done) begin
          state_d  = otpc_pkg::ST_VFY_WAIT;
          tmr_load = 1'b1;
          tmr_val  = `OTPC_TMR_BITS'(`OTPC_OEV_CYC);
        end
      end
      otpc_pkg::ST_VFY_WAIT: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = `OTPC_TMR_BITS'(`OTPC_FLOAT_CYC);
          state_d  = prog_finish ? otpc_pkg::ST_FLOAT : otpc_pkg::ST_REFLOAT;
        end
      end
      otpc_pkg::ST_REFLOAT: begin
        if (tmr_done) begin
          state_d  = otpc_pkg::ST_SETUP;
          tmr_load = 1'b1;
          tmr_val  = `OTPC_TMR_BITS'(`OTPC_SETUP_CYC);
        end
      end
      otpc_pkg::ST_ACCESS: begin
        if (tmr_done) begin
          state_d  = otpc_pkg::ST_FLOAT;
          tmr_load = 1'b1;
          tmr_val  = `OTPC_TMR_BITS'(`OTPC_FLOAT_CYC);
        end
      end
      otpc_pkg::ST_FLOAT: begin
        if (tmr_done) begin
          state_d = otpc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = otpc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= otpc_pkg::ST_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // one address per command, taken in turn
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cur_q <= '0;
    end else if (clk_en && accept) begin
      cur_q <= cmd;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pulses_q <= '0;
    end else if (clk_en) begin
      if (accept) begin
        pulses_q <= '0;
      end else if (state_q == otpc_pkg::ST_SETUP && tmr_done) begin
        pulses_q <= pulses_q + `OTPC_PW_BITS'(1);
      end
    end
  end

  // control pins; select and gate are the only per-device pins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins <= '{address_lines: '0, ce_n: 1'b1, oe_n: 1'b1, program_strobe_n: 1'b1,
                vpp_prog: 1'b0, identify_high_voltage: 1'b0};
    end else if (clk_en) begin
      if (accept) begin
        pins.address_lines <= cmd.addr;
        pins.ce_n          <= 1'b0;
        if (cmd.op == otpc_pkg::OP_PROG) begin
          // program supply up with gate high
          pins.oe_n     <= 1'b1;
          pins.vpp_prog <= 1'b1;
        end else begin
          // gate acts as the read strobe
          pins.oe_n <= 1'b0;
          if (cmd.op == otpc_pkg::OP_IDENT) begin
            // raise line 9; others low; line 0 picks byte
            pins.address_lines <= `OTPC_AW'(cmd.addr[`OTPC_ID_SEL_BIT]);
            pins.identify_high_voltage <= 1'b1;
          end
        end
      end else if (tmr_done) begin
        case (state_q)
          otpc_pkg::ST_SETUP: begin
            pins.program_strobe_n <= 1'b0;
          end
          otpc_pkg::ST_PULSE: begin
            pins.program_strobe_n <= 1'b1;
          end
          otpc_pkg::ST_HOLD: begin
            pins.oe_n <= 1'b0;
          end
          otpc_pkg::ST_VFY_WAIT: begin
            pins.oe_n <= 1'b1;
            if (prog_finish) begin
              pins.ce_n     <= 1'b1;
              pins.vpp_prog <= 1'b0;
            end
          end
          otpc_pkg::ST_ACCESS: begin
            // select high puts the part in standby
            pins.ce_n                  <= 1'b1;
            pins.oe_n                  <= 1'b1;
            pins.identify_high_voltage <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // data lines; whole byte driven together
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_lines_o  <= '0;
      data_lines_oe <= 1'b0;
    end else if (clk_en) begin
      if (accept && cmd.op == otpc_pkg::OP_PROG) begin
        data_lines_o  <= cmd.data;
        data_lines_oe <= 1'b1;
      end else if (tmr_done && state_q == otpc_pkg::ST_HOLD) begin
        data_lines_oe <= 1'b0;
      end else if (tmr_done && state_q == otpc_pkg::ST_REFLOAT) begin
        // gate has been high long enough for the part to float
        data_lines_oe <= 1'b1;
      end
    end
  end

  // answers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      if (tmr_done && (state_q == otpc_pkg::ST_ACCESS ||
          (state_q == otpc_pkg::ST_VFY_WAIT && prog_finish))) begin
        rsp_valid     <= 1'b1;
        rsp.data      <= data_lines_i;
        // verify command compares at normal supply
        rsp.match     <= match;
        rsp.parity_ok <= ^data_lines_i;
        rsp.pulses    <= pulses_q;
      end
    end
  end

  // helper: length of the current strobe low time
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      low_cnt_q <= '0;
    end else if (clk_en) begin
      low_cnt_q <= pins.program_strobe_n ? '0 : low_cnt_q + `OTPC_TMR_BITS'(1);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_pulse_width_exact: assert property ($rose(pins.program_strobe_n) |-> low_cnt_q == PW_CYC)
    else $error("program strobe low time differs from nominal");
  chk_strobe_needs_sel: assert property (!pins.program_strobe_n |-> !pins.ce_n && pins.vpp_prog)
    else $error("strobe low without select or program supply");
  chk_prog_gate_high: assert property (!pins.program_strobe_n |-> pins.oe_n)
    else $error("gate low during program pulse");
  chk_bus_no_contention: assert property (data_lines_oe |-> pins.oe_n)
    else $error("host drives data while part gate is low");
  chk_pulse_lines_stable: assert property (!pins.program_strobe_n && $past(!pins.program_strobe_n)
      |-> $stable(pins.address_lines) && $stable(data_lines_o) && data_lines_oe)
    else $error("address or data moved during program pulse");
  chk_pulse_count_limit: assert property ($fell(pins.program_strobe_n)
      |-> pulses_q <= `OTPC_MAX_PULSES)
    else $error("too many program pulses");
  chk_ident_addr_low: assert property (pins.identify_high_voltage
      |-> pins.address_lines[`OTPC_AW-1:1] == '0 && !pins.ce_n && !pins.oe_n)
    else $error("identify without clear address or enables");
  chk_verify_supply_low: assert property (rsp_valid && cur_q.op == otpc_pkg::OP_VERIFY
      |-> !pins.vpp_prog && $past(!pins.vpp_prog, 2))
    else $error("final verify not at normal supply");
  chk_read_access_time: assert property ($rose(rsp_valid) && cur_q.op == otpc_pkg::OP_READ
      && $past(clk_en, 1) |-> $past(!pins.oe_n, 7))
    else $error("read sampled before access time");

  cov_prog_ok: cover property (rsp_valid && cur_q.op == otpc_pkg::OP_PROG && rsp.match);
  cov_prog_retry: cover property ($fell(pins.program_strobe_n) && pulses_q > `OTPC_PW_BITS'(1));
  cov_ident: cover property (rsp_valid && cur_q.op == otpc_pkg::OP_IDENT);
  cov_read: cover property (rsp_valid && cur_q.op == otpc_pkg::OP_READ);

endmodule // otpc_ctrl

// file: sim/otpc_dev_model.sv
// behavioural model of the one-time-programmable byte memory
`timescale 1ns/1ps
module otpc_dev_model #(
  // identifier values are arbitrary, chosen with odd parity
  parameter logic [7:0] MFR_CODE = 8'h07,
  parameter logic [7:0] DEV_CODE = 8'h8F
) (
  input  otpc_pkg::otpc_pins_t pins,
  input  wire logic [7:0]      bus_in,
  input  wire logic [7:0]      pulses_needed,
  output logic [7:0]           q,
  output logic                 q_oe
);
  logic [7:0]  mem [0:131071];
  logic [16:0] last_a;
  int          hits;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    last_a = 17'h1FFFF;
    hits = 0;
  end
  // strobe programs only when selected at high supply
  always @(negedge pins.program_strobe_n) begin
    if (pins.vpp_prog && !pins.ce_n) begin
      if (pins.address_lines != last_a) hits = 0;
      last_a = pins.address_lines;
      hits++;
      if (hits >= pulses_needed) mem[last_a] = mem[last_a] & bus_in;
    end
  end
  // drive only with select and gate low
  assign q_oe = !pins.ce_n && !pins.oe_n;
  assign q = pins.identify_high_voltage ? (pins.address_lines[0] ? DEV_CODE : MFR_CODE)
                                        : mem[pins.address_lines];
endmodule // otpc_dev_model

// file: sim/tb_top.sv
// self-checking bench for the memory host controller
`timescale 1ns/1ps
module tb_top;
  logic                 sys_clk;
  logic                 rst;
  logic                 clk_en;
  logic                 cmd_valid;
  logic                 cmd_ready;
  otpc_pkg::otpc_cmd_t  cmd;
  logic                 rsp_valid;
  otpc_pkg::otpc_rsp_t  rsp;
  otpc_pkg::otpc_pins_t pins;
  logic [7:0]           data_lines_o;
  logic                 data_lines_oe;
  logic [7:0]           bus;
  logic [7:0]           bus_last;
  logic [7:0]           dev_q;
  logic                 dev_oe;
  logic [7:0]           need;
  logic [16:0]          id_addr;
  int                   lo_cnt;
  int                   last_w;
  int                   bad;
  int                   lat;
  int                   miscompares;
  int                   checks;

  otpc_ctrl otpc_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
    .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe), .data_lines_i(bus));
  otpc_dev_model otpc_dev_model_inst (.pins(pins), .bus_in(bus), .pulses_needed(need),
    .q(dev_q), .q_oe(dev_oe));

  // released bus shows a changing pattern, not the last value
  assign bus = data_lines_oe ? data_lines_o : (dev_oe ? dev_q : ~bus_last);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    bus_last <= bus;
    if (pins.identify_high_voltage) id_addr <= pins.address_lines;
    if (data_lines_oe && dev_oe) bad <= bad + 1;
    if (!pins.program_strobe_n && (pins.ce_n || !pins.vpp_prog)) bad <= bad + 1;
    if (!pins.program_strobe_n) lo_cnt <= lo_cnt + 1;
    else if (lo_cnt != 0) begin
      last_w <= lo_cnt;
      lo_cnt <= 0;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one command, latency counted in edges after acceptance
  task automatic run_cmd(input otpc_pkg::otpc_op_t op, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    cmd.op = op;
    cmd.addr = a;
    cmd.data = d;
    cmd_valid = 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 1;
    while (rsp_valid !== 1'b1 && n < 70000) begin
      @(negedge sys_clk);
      n++;
    end
    lat = n;
  endtask

  task automatic t_reset;
    chk("pins", {10'h0, 17'h0, 5'b11100}, {10'h0, pins});
    chk("oe", 32'h0, {31'h0, data_lines_oe});
    chk("ready", 32'h1, {31'h0, cmd_ready});
    chk("rsp valid", 32'h0, {31'h0, rsp_valid});
  endtask

  task automatic t_blank_read;
    int k;
    run_cmd(otpc_pkg::OP_READ, 17'h1FFFF, 8'h00);
    chk("blank", 32'hFF, {24'h0, rsp.data});
    chk("blank parity", 32'h0, {31'h0, rsp.parity_ok});
    chk("read lat", 32'h8, lat);
    // pins stay released for the float time before the next command
    k = 0;
    while (cmd_ready !== 1'b1 && k < 20) begin
      @(negedge sys_clk);
      k++;
    end
    chk("ready gap", 32'h4, k);
  endtask

  // a low enable for three edges stretches the access by three cycles
  task automatic t_freeze;
    while (cmd_ready !== 1'b1) begin
      @(negedge sys_clk);
    end
    fork
      run_cmd(otpc_pkg::OP_READ, 17'h10000, 8'h00);
      begin
        repeat (3) @(negedge sys_clk);
        clk_en = 1'b0;
        repeat (3) @(negedge sys_clk);
        clk_en = 1'b1;
      end
    join
    chk("frozen data", 32'h3C, {24'h0, rsp.data});
    chk("frozen lat", 32'hB, lat);
  endtask

  task automatic t_prog(input logic [7:0] n_need, input logic [16:0] a, input logic [7:0] d,
                        input logic [4:0] n_pul, input logic ok);
    need = n_need;
    run_cmd(otpc_pkg::OP_PROG, a, d);
    chk("pulses", {27'h0, n_pul}, {27'h0, rsp.pulses});
    chk("match", {31'h0, ok}, {31'h0, rsp.match});
    chk("prog lat", 2605 + (n_pul - 1) * 2608, lat);
    chk("strobe width", 32'd2500, last_w);
  endtask

  task automatic t_program;
    t_prog(8'h01, 17'h00005, 8'hA5, 5'h01, 1'b1);
    t_prog(8'h02, 17'h10000, 8'h3C, 5'h02, 1'b1);
    t_prog(8'h63, 17'h00007, 8'h00, 5'h19, 1'b0);
    run_cmd(otpc_pkg::OP_READ, 17'h00005, 8'h00);
    chk("readback", 32'hA5, {24'h0, rsp.data});
  endtask

  task automatic t_verify;
    run_cmd(otpc_pkg::OP_VERIFY, 17'h10000, 8'h3C);
    chk("verify ok", 32'h1, {31'h0, rsp.match});
    run_cmd(otpc_pkg::OP_VERIFY, 17'h00005, 8'h5A);
    chk("verify bad", 32'h0, {31'h0, rsp.match});
  endtask

  task automatic t_ident;
    for (int i = 0; i < 2; i++) begin
      run_cmd(otpc_pkg::OP_IDENT, {16'hFFFF, i[0]}, 8'h00);
      chk("id byte", i ? 32'h8F : 32'h07, {24'h0, rsp.data});
      chk("id parity", 32'h1, {31'h0, rsp.parity_ok});
      chk("id addr", {31'h0, i[0]}, {15'h0, id_addr});
    end
  endtask

  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    need = 8'h01;
    bus_last = 8'h00;
    id_addr = 17'h0;
    lo_cnt = 0;
    last_w = 0;
    bad = 0;
    miscompares = 0;
    checks = 0;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_blank_read();
    t_program();
    t_freeze();
    t_verify();
    t_ident();
    chk("contention", 32'h0, bad);
    give_verdict();
  end

  initial begin
    #(100000 * 40);
    miscompares++;
    give_verdict();
  end
endmodule // tb_top
